// >>> cst_pkg.sv
// cst_pkg.sv: types shared by the skip-test unit
// assumes decoded opcodes arrive from the program sequencer
package cst_pkg;

    typedef enum logic [2:0] {
        CST_OP_NONE,
        CST_OP_CONV,
        CST_OP_PORT,
        CST_OP_PIN,
        CST_OP_PDOWN
    } cst_op_t;

    typedef struct packed {
        logic valid;
        cst_op_t op;
    } cst_instr_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [3:0] addr;
        logic [3:0] wdata;
    } cst_bus_t;

endpackage

// >>> cst_seq_model.sv
// cst_seq_model.sv: program sequencer stand-in feeding decoded words
// assumes the bench steers go and op on CLK rising edges
`timescale 1ns/10ps

module cst_seq_model (
    input wire logic go,
    input wire cst_pkg::cst_op_t op,
    input wire logic skip_next,
    output cst_pkg::cst_instr_t instr,
    output logic discard
);
    // one word per valid cycle, no multi-word forms
    always_comb begin
        instr.valid = go;
        instr.op = go ? op : cst_pkg::CST_OP_NONE;
    end
    // word fetched while skip pends is thrown away
    assign discard = go & skip_next;
endmodule

// >>> cst_skip_map.svh
// cst_skip_map.svh: offsets, field positions, reset values of the skip-test unit
// assumes a 4-bit register port and a single instruction clock
`ifndef CST_SKIP_MAP_SVH
`define CST_SKIP_MAP_SVH

`define CST_AW 4
`define CST_DW 4

`define CST_OFS_IRQCTL2 4'h0
`define CST_OFS_EXTCTL 4'h1
`define CST_OFS_STATUS 4'h2
`define CST_OFS_MASK 4'h3
`define CST_OFS_FLAGS 4'h4

`define CST_BIT_CONV_IEN 2
`define CST_BIT_PIN_POL 2

`define CST_EV_CONV_SET 0
`define CST_EV_SKIP 1
`define CST_EV_NOP 2

`define CST_FL_CONV 0
`define CST_FL_PDOWN 1
`define CST_FL_PEND 2

`define CST_RST_CTL 4'h0
`define CST_RST_MASK 4'h0

`endif

// >>> cst_skip_unit.sv
// cst_skip_unit.sv: execution of the four single-bit skip-test instructions
// assumes the sequencer presents one decoded instruction per valid cycle on CLK
//
// Overview of operation
// (RULE_01) conversion skip with enable 0 and flag 1 suppresses the next instruction
// (RULE_02) a taken conversion skip clears the conversion-complete flag
// (RULE_03) conversion skip with flag 0 lets the next instruction run
// (RULE_04) conversion skip with enable 1 is a no-op, flag untouched
// (RULE_05) that enable is bit 2 of the second interrupt control register
// (RULE_06) port-bit skip skips when the input port bit reads 1
// (RULE_07) polarity 0: pin-level skip skips when the interrupt pin is low
// (RULE_08) polarity 1: pin-level skip skips when the interrupt pin is high
// (RULE_09) the polarity is bit 2 of the external interrupt control register
// (RULE_10) power-down skip skips when the power-down flag is 1, flag kept
// (RULE_11) each test takes one word, one cycle, and leaves carry alone
// (RULE_12) a skipped instruction is fetched, discarded, without side effects
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "cst_skip_map.svh"

module cst_skip_unit (
    input wire logic CLK,
    input wire logic RST_B,
    input wire cst_pkg::cst_instr_t INSTR,
    input wire logic CONV_DONE,
    input wire logic PDOWN_FLAG,
    input wire logic PORT_BIT,
    input wire logic EXT_INT_PIN,
    input wire cst_pkg::cst_bus_t BUS,
    output logic [3:0] RDATA,
    output logic SKIP_NEXT,
    output logic CONV_FLAG,
    output logic IRQ
);

    function automatic logic pin_match(input logic lvl, input logic pol);
        pin_match = (lvl == pol);
    endfunction

    // pin synchronisers: first stage feeds only the second
    logic port_m_r;
    logic port_s_r;
    logic pin_m_r;
    logic pin_s_r;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            port_m_r <= 1'b0;
            port_s_r <= 1'b0;
            pin_m_r <= 1'b1;
            pin_s_r <= 1'b1;
        end else begin
            port_m_r <= PORT_BIT;
            port_s_r <= port_m_r;
            pin_m_r <= EXT_INT_PIN;
            pin_s_r <= pin_m_r;
        end
    end

    // control registers
    logic [3:0] irqctl2_r;
    logic [3:0] extctl_r;
    logic [3:0] status_r;
    logic [3:0] mask_r;
    logic [3:0] status_nxt;
    logic conv_flag_r;
    logic conv_flag_nxt;
    logic skip_r;
    logic skip_nxt;

    logic conv_ien;
    logic pin_pol;
    assign conv_ien = irqctl2_r[`CST_BIT_CONV_IEN]; // [RULE_05]
    assign pin_pol = extctl_r[`CST_BIT_PIN_POL]; // [RULE_09]

    // an instruction arriving while a skip is pending is the victim: it does nothing
    logic exec;
    assign exec = INSTR.valid && !skip_r; // [RULE_12]

    logic is_conv;
    logic is_port;
    logic is_pin;
    logic is_pd;
    assign is_conv = exec && (INSTR.op == cst_pkg::CST_OP_CONV);
    assign is_port = exec && (INSTR.op == cst_pkg::CST_OP_PORT);
    assign is_pin = exec && (INSTR.op == cst_pkg::CST_OP_PIN);
    assign is_pd = exec && (INSTR.op == cst_pkg::CST_OP_PDOWN);

    logic conv_take;
    logic conv_nop;
    logic take;
    assign conv_take = is_conv && !conv_ien && conv_flag_r; // [RULE_01] [RULE_03]
    assign conv_nop = is_conv && conv_ien; // [RULE_04]

    always_comb begin
        take = conv_take;
        if (is_port && port_s_r) begin // [RULE_06]
            take = 1'b1;
        end else if (is_pin && pin_match(pin_s_r, pin_pol)) begin // [RULE_07] [RULE_08]
            take = 1'b1;
        end else if (is_pd && PDOWN_FLAG) begin // [RULE_10]
            take = 1'b1;
        end
    end

    // skip decided in the same cycle; carry is never touched here
    always_comb begin
        skip_nxt = skip_r;
        if (INSTR.valid && skip_r) begin // [RULE_12]
            skip_nxt = 1'b0;
        end else if (take) begin // [RULE_11]
            skip_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            skip_r <= 1'b0;
        end else begin
            skip_r <= skip_nxt;
        end
    end

    // set from the converter wins over the clear of a taken skip
    always_comb begin
        conv_flag_nxt = conv_flag_r;
        if (conv_take) begin
            conv_flag_nxt = 1'b0; // [RULE_02]
        end
        if (CONV_DONE) begin
            conv_flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            conv_flag_r <= 1'b0;
        end else begin
            conv_flag_r <= conv_flag_nxt;
        end
    end

    // register writes
    logic wr_ctl2;
    logic wr_ext;
    logic wr_sts;
    logic wr_msk;
    assign wr_ctl2 = BUS.we && (BUS.addr == `CST_OFS_IRQCTL2);
    assign wr_ext = BUS.we && (BUS.addr == `CST_OFS_EXTCTL);
    assign wr_sts = BUS.we && (BUS.addr == `CST_OFS_STATUS);
    assign wr_msk = BUS.we && (BUS.addr == `CST_OFS_MASK);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irqctl2_r <= `CST_RST_CTL;
            extctl_r <= `CST_RST_CTL;
            mask_r <= `CST_RST_MASK;
        end else begin
            if (wr_ctl2) begin
                irqctl2_r <= BUS.wdata;
            end
            if (wr_ext) begin
                extctl_r <= BUS.wdata;
            end
            if (wr_msk) begin
                mask_r <= BUS.wdata;
            end
        end
    end

    // sticky events, write one to clear; a new event in the clear cycle survives
    logic [3:0] ev;
    always_comb begin
        ev = 4'h0;
        ev[`CST_EV_CONV_SET] = CONV_DONE;
        ev[`CST_EV_SKIP] = take;
        ev[`CST_EV_NOP] = conv_nop;
        status_nxt = status_r;
        if (wr_sts) begin
            status_nxt = status_r & ~BUS.wdata;
        end
        status_nxt = status_nxt | ev;
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_r <= 4'h0;
        end else begin
            status_r <= status_nxt;
        end
    end

    logic [3:0] mask_nxt;
    assign mask_nxt = wr_msk ? BUS.wdata : mask_r;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_nxt & mask_nxt);
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    logic [3:0] rd_val;
    always_comb begin
        rd_val = 4'h0;
        if (BUS.addr == `CST_OFS_IRQCTL2) begin
            rd_val = irqctl2_r;
        end else if (BUS.addr == `CST_OFS_EXTCTL) begin
            rd_val = extctl_r;
        end else if (BUS.addr == `CST_OFS_STATUS) begin
            rd_val = status_r;
        end else if (BUS.addr == `CST_OFS_MASK) begin
            rd_val = mask_r;
        end else if (BUS.addr == `CST_OFS_FLAGS) begin
            rd_val[`CST_FL_CONV] = conv_flag_r;
            rd_val[`CST_FL_PDOWN] = PDOWN_FLAG;
            rd_val[`CST_FL_PEND] = skip_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 4'h0;
        end else begin
            RDATA <= BUS.re ? rd_val : 4'h0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SKIP_NEXT <= 1'b0;
            CONV_FLAG <= 1'b0;
        end else begin
            SKIP_NEXT <= skip_nxt;
            CONV_FLAG <= conv_flag_nxt;
        end
    end

    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    a_conv_skip_taken: assert property ( // [RULE_01]
        is_conv && !conv_ien && conv_flag_r |=> skip_r && SKIP_NEXT)
        else $error("conversion skip not taken");

    a_conv_flag_clear: assert property ( // [RULE_02]
        conv_take && !CONV_DONE |=> !conv_flag_r && !CONV_FLAG)
        else $error("conversion flag not cleared after skip");

    a_conv_no_flag: assert property ( // [RULE_03]
        is_conv && !conv_flag_r |=> !skip_r)
        else $error("skip taken with conversion flag clear");

    a_conv_nop_keep: assert property ( // [RULE_04]
        is_conv && conv_ien |=> !skip_r && (conv_flag_r == ($past(conv_flag_r) || $past(CONV_DONE))))
        else $error("conversion skip not a no-op when enabled");

    a_conv_enable_bit: assert property ( // [RULE_05]
        is_conv && conv_flag_r && irqctl2_r[`CST_BIT_CONV_IEN] |=> !skip_r && conv_flag_r)
        else $error("enable bit 2 not gating conversion skip");

    a_port_skip_rel: assert property ( // [RULE_06]
        is_port |=> skip_r == $past(port_s_r))
        else $error("port skip disagrees with port bit");

    a_pin_low_pol: assert property ( // [RULE_07]
        is_pin && !extctl_r[`CST_BIT_PIN_POL] |=> skip_r == !$past(pin_s_r))
        else $error("pin skip wrong for polarity 0");

    a_pin_high_pol: assert property ( // [RULE_08]
        is_pin && extctl_r[`CST_BIT_PIN_POL] |=> skip_r == $past(pin_s_r))
        else $error("pin skip wrong for polarity 1");

    a_pin_pol_write: assert property ( // [RULE_09]
        wr_ext |=> pin_pol == $past(BUS.wdata[`CST_BIT_PIN_POL]))
        else $error("polarity not taken from bit 2");

    a_pdown_skip_rel: assert property ( // [RULE_10]
        is_pd |=> skip_r == $past(PDOWN_FLAG))
        else $error("power-down skip disagrees with flag");

    a_skip_one_cycle: assert property ( // [RULE_11]
        $rose(skip_r) |-> $past(INSTR.valid) && $past(take))
        else $error("skip not decided in the instruction cycle");

    a_victim_discard: assert property ( // [RULE_12]
        INSTR.valid && skip_r && !CONV_DONE |=> !skip_r && (conv_flag_r == $past(conv_flag_r)))
        else $error("discarded instruction had an effect");

    a_irq_tracks: assert property (
        (|(status_r & mask_r)) |-> IRQ)
        else $error("interrupt low with unmasked status set");

    c_conv_skip: cover property (conv_take ##1 INSTR.valid && skip_r);
    c_pin_skip: cover property (is_pin && take);
    c_nop_conv: cover property (conv_nop && conv_flag_r);
    c_set_clear_race: cover property (conv_take && CONV_DONE);

endmodule

// >>> testbench.sv
// testbench.sv: self-checking bench for the skip-test unit
// assumes drivers change on rising edges; checks sample 1 ns later
`timescale 1ns/10ps
`include "cst_skip_map.svh"

module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic go = 1'b0;
    cst_pkg::cst_op_t op = cst_pkg::CST_OP_NONE;
    cst_pkg::cst_instr_t instr;
    cst_pkg::cst_bus_t bus = '0;
    logic conv_done = 1'b0;
    logic pdown = 1'b0;
    logic port = 1'b0;
    logic pin = 1'b1;
    logic [3:0] rdata;
    logic skip_next, conv_flag, irq, discard;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    cst_seq_model cst_seq_model_inst (.go(go), .op(op), .skip_next(skip_next), .instr(instr), .discard(discard));
    cst_skip_unit cst_skip_unit_inst (.CLK(clk), .RST_B(rst_b), .INSTR(instr), .CONV_DONE(conv_done),
        .PDOWN_FLAG(pdown), .PORT_BIT(port), .EXT_INT_PIN(pin), .BUS(bus), .RDATA(rdata),
        .SKIP_NEXT(skip_next), .CONV_FLAG(conv_flag), .IRQ(irq));

    task automatic test_done;
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // every task below is entered and left on a rising edge
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        bus.we <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [3:0] exp);
        bus.re <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.re <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
        @(posedge clk);
    endtask

    task automatic pulse_conv;
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        @(posedge clk);
    endtask

    // test word, then a follower word; follower must be dropped when skip pends
    task automatic issue(input cst_pkg::cst_op_t o, input cst_pkg::cst_op_t f, input logic es, input logic ef);
        go <= 1'b1;
        op <= o;
        @(posedge clk);
        op <= f;
        #1;
        chk("skip_next", {3'h0, skip_next}, {3'h0, es});
        chk("discard", {3'h0, discard}, {3'h0, es});
        @(posedge clk);
        go <= 1'b0;
        #1;
        chk("skip_after", {3'h0, skip_next}, 4'h0);
        chk("conv_flag", {3'h0, conv_flag}, {3'h0, ef});
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("reset_outs", {1'b0, skip_next, conv_flag, irq}, 4'h0);
        @(posedge clk);
        for (int a = 0; a < 6; a++) begin
            rd(a[3:0], 4'h0);
        end
        // unmapped place and read-only flags ignore writes
        wr(4'h5, 4'hf);
        rd(4'h5, 4'h0);
        wr(`CST_OFS_FLAGS, 4'hf);
        rd(`CST_OFS_FLAGS, 4'h0);
        issue(cst_pkg::CST_OP_CONV, cst_pkg::CST_OP_NONE, 1'b0, 1'b0);
        pulse_conv();
        wr(`CST_OFS_IRQCTL2, 4'hb);
        issue(cst_pkg::CST_OP_CONV, cst_pkg::CST_OP_NONE, 1'b1, 1'b0);
        pulse_conv();
        wr(`CST_OFS_IRQCTL2, 4'h4);
        issue(cst_pkg::CST_OP_CONV, cst_pkg::CST_OP_NONE, 1'b0, 1'b1);
        wr(`CST_OFS_IRQCTL2, 4'h0);
        pdown <= 1'b1;
        // dropped follower would otherwise skip again and clear the flag
        issue(cst_pkg::CST_OP_PDOWN, cst_pkg::CST_OP_CONV, 1'b1, 1'b1);
        rd(`CST_OFS_FLAGS, 4'h3);
        // skip pending survives idle cycles; the victim must not skip again
        go <= 1'b1;
        op <= cst_pkg::CST_OP_PDOWN;
        @(posedge clk);
        go <= 1'b0;
        rd(`CST_OFS_FLAGS, 4'h7);
        issue(cst_pkg::CST_OP_PDOWN, cst_pkg::CST_OP_NONE, 1'b0, 1'b1);
        pdown <= 1'b0;
        issue(cst_pkg::CST_OP_PDOWN, cst_pkg::CST_OP_NONE, 1'b0, 1'b1);
        rd(`CST_OFS_STATUS, 4'h7);
        #1;
        chk("irq_masked", {3'h0, irq}, 4'h0);
        @(posedge clk);
        wr(`CST_OFS_MASK, 4'h4);
        rd(`CST_OFS_MASK, 4'h4);
        #1;
        chk("irq_set", {3'h0, irq}, 4'h1);
        @(posedge clk);
        wr(`CST_OFS_STATUS, 4'h4);
        rd(`CST_OFS_STATUS, 4'h3);
        #1;
        chk("irq_clear", {3'h0, irq}, 4'h0);
        @(posedge clk);
        // pins pass a two-stage synchroniser, so settle three cycles
        for (int v = 0; v < 2; v++) begin
            port <= v[0];
            repeat (3) @(posedge clk);
            issue(cst_pkg::CST_OP_PORT, cst_pkg::CST_OP_NONE, v[0], 1'b1);
        end
        for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < 2; l++) begin
                wr(`CST_OFS_EXTCTL, p[0] ? 4'h4 : 4'hb);
                pin <= l[0];
                repeat (3) @(posedge clk);
                issue(cst_pkg::CST_OP_PIN, cst_pkg::CST_OP_NONE, l == p, 1'b1);
            end
        end
        // converter set in the clear cycle wins, flag stays up
        fork
            issue(cst_pkg::CST_OP_CONV, cst_pkg::CST_OP_NONE, 1'b1, 1'b1);
            pulse_conv();
        join
        test_done();
    end
endmodule
